// ===== pcls_map.svh
// Offsets, field positions and reset values of the configuration slice.
// Assumes byte addresses of 32-bit configuration dwords from the host port.
`ifndef PCLS_MAP_SVH
`define PCLS_MAP_SVH

// Dword byte addresses
`define PCLS_DW_LATENCY      8'h3c
`define PCLS_DW_ENDIAN       8'h40
`define PCLS_DW_CAPHDR       8'h44

// Printed register offsets
`define PCLS_OFF_LATENCY     8'h3e
`define PCLS_OFF_ENDIAN      8'h40
`define PCLS_OFF_CAPHDR      8'h44

// Burst latency hint layout and default
`define PCLS_LAT_RESET       16'h0402
`define PCLS_LAT_MAXLAT_HI   15
`define PCLS_LAT_MAXLAT_LO   8
`define PCLS_LAT_MINGNT_HI   7
`define PCLS_LAT_MINGNT_LO   0

// Endian control layout and reset
`define PCLS_END_SWAP_BIT    0
`define PCLS_END_RESET       1'h0
`define PCLS_END_SWAP_LANE   0
`define PCLS_END_RSVD_ZERO   31'h00000000

// Capability header contents
`define PCLS_CAP_KIND_CODE   8'h01
`define PCLS_CAP_NEXT_PTR    8'h00

// Misc widths and constants
`define PCLS_ZERO16          16'h0000
`define PCLS_ZERO32          32'h00000000
`define PCLS_DW_ADDR_MASK    8'hfc

`endif

// ===== pcls_pkg.sv
// Types of the configuration slice.
// Assumes nothing beyond the map header.
package pcls_pkg;
	typedef logic [31:0] pcls_dword_t;
	typedef logic [15:0] pcls_half_t;
	typedef logic [7:0]  pcls_addr_t;
	typedef logic [3:0]  pcls_be_t;
	typedef enum logic [0:0] {
		PCLS_LOAD_WAIT = 1'b0,
		PCLS_LOAD_DONE = 1'b1
	} pcls_load_t;
endpackage

// ===== pcls_quad_swap.sv
// Quadlet byte swapper with a registered output stage.
// Assumes the caller selects swapping per quadlet through swap_i.
`include "pcls_map.svh"
`timescale 1ns/1ps
module pcls_quad_swap (
	input  wire logic             clk_i,   // System clock
	input  wire logic             rst_i,   // Synchronous reset
	input  wire logic             swap_i,  // Swap enable
	input  wire logic             valid_i, // Quadlet present
	input  wire pcls_pkg::pcls_dword_t data_i,  // Quadlet in
	output logic                  valid_o, // Quadlet out valid
	output pcls_pkg::pcls_dword_t data_o   // Quadlet out
);
	import pcls_pkg::*;

	// Reverse the four bytes of a quadlet
	function automatic pcls_dword_t swap_bytes(input pcls_dword_t d);
		swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	// Registered valid
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
		end else begin
			valid_o <= valid_i;
		end
	end

	// Registered data, swapped on demand
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_o <= `PCLS_ZERO32;
		end else if (valid_i) begin
			data_o <= swap_i ? swap_bytes(data_i) : data_i;
		end
	end
endmodule

// ===== pcls_cfg_slice.sv
// Configuration slice: latency hint, endian control and capability header,
// plus the byte swap on the quadlet data path.
// Assumes one-clock configuration requests and EEPROM words on the same clock.
// Assumes the EEPROM reader hands over the hint word as a single strobe.
// Assumes the host uses dword byte addresses with byte enables.
`include "pcls_map.svh"
`timescale 1ns/1ps

// Behaviour
// - With an EEPROM present, the latency hint is filled from EEPROM data after reset.
// - Without an EEPROM, the latency hint reads its default 0402h.
// - Bits 15 to 8 of the hint give maximum latency, read-only to the host.
// - Bits 7 to 0 of the hint give minimum grant, read-only to the host.
// - With the swap bit set, every quadlet through the data path is byte-swapped.
// - Bits 31 to 1 of the endian control register always read zero.
// - The capability header low byte always reads 01h.
// - The capability header high byte always reads 00h.
module pcls_cfg_slice (
	input  wire logic                  clk_i,         // System clock, 125 MHz
	input  wire logic                  rst_i,         // Global reset, sync high
	input  wire logic                  cfg_req_i,     // Config access request
	input  wire logic                  cfg_we_i,      // Write when high
	input  wire pcls_pkg::pcls_addr_t  cfg_addr_i,    // Byte address
	input  wire pcls_pkg::pcls_be_t    cfg_be_i,      // Byte enables, high active
	input  wire pcls_pkg::pcls_dword_t cfg_wdata_i,   // Write data
	output logic                       cfg_ack_o,     // Access done pulse
	output pcls_pkg::pcls_dword_t      cfg_rdata_o,   // Read data
	input  wire logic                  ee_present_i,  // EEPROM detected
	input  wire logic                  ee_valid_i,    // EEPROM hint word strobe
	input  wire pcls_pkg::pcls_half_t  ee_data_i,     // EEPROM hint word
	output logic                       ee_loaded_o,   // Hint load finished
	output logic                       swap_en_o,     // Swap bit state
	input  wire logic                  wr_valid_i,    // Host write quadlet valid
	input  wire pcls_pkg::pcls_dword_t wr_data_i,     // Host write quadlet
	output logic                       wr_valid_o,    // Quadlet to core valid
	output pcls_pkg::pcls_dword_t      wr_data_o,     // Quadlet to core
	input  wire logic                  rd_valid_i,    // Core read quadlet valid
	input  wire pcls_pkg::pcls_dword_t rd_data_i,     // Core read quadlet
	output logic                       rd_valid_o,    // Quadlet to host valid
	output pcls_pkg::pcls_dword_t      rd_data_o      // Quadlet to host
);
	import pcls_pkg::*;

	// Stored state
	// Only the swap bit, the hint, the load phase, the ack, the read data and the two quadlet swap stages hold state here; the rest is fixed
	pcls_half_t  lat_q;       // Burst latency hint
	logic        swap_q;      // Byte swap enable
	pcls_load_t  load_q;      // EEPROM load phase
	pcls_load_t  load_d;      // Next load phase

	// Decoded access
	pcls_addr_t  dw_addr;     // Dword address of the request
	logic        hit_endian;  // Request targets endian control
	logic        rd_req;      // Read request this edge
	logic        wr_req;      // Write request this edge
	logic        swap_wr;     // Write reaches the swap bit

	// EEPROM side
	logic        ee_take;     // Hint word accepted this edge

	// Read word images
	logic [7:0]  max_latency; // Hint upper byte
	logic [7:0]  min_grant;   // Hint lower byte
	pcls_dword_t hint_word;   // Latency dword image
	pcls_dword_t endian_word; // Endian control image
	pcls_dword_t cap_word;    // Capability header image
	pcls_dword_t rdata_d;     // Selected read word

	// Align to the dword holding the register
	function automatic pcls_addr_t dword_of(input pcls_addr_t a);
		dword_of = a & `PCLS_DW_ADDR_MASK;
	endfunction

	// Put a half word in the upper half of a dword
	function automatic pcls_dword_t upper_half(input pcls_half_t h);
		upper_half = {h, `PCLS_ZERO16};
	endfunction

	// Put a half word in the lower half of a dword
	function automatic pcls_dword_t lower_half(input pcls_half_t h);
		lower_half = {`PCLS_ZERO16, h};
	endfunction

	// Dword decode; the low address bits are masked off and ignored
	// Byte enables, not address bits, pick the lanes inside a dword
	assign dw_addr    = dword_of(cfg_addr_i);
	assign hit_endian = (dw_addr == `PCLS_DW_ENDIAN);

	// Access kind
	assign rd_req = cfg_req_i && !cfg_we_i;
	assign wr_req = cfg_req_i && cfg_we_i;

	// Only byte lane 0 holds a writable bit; other writes are dropped
	assign swap_wr = wr_req && hit_endian && cfg_be_i[`PCLS_END_SWAP_LANE];

	// A word counts only once, while the load is still pending
	// Without an EEPROM the default stays and nothing is taken
	assign ee_take = (load_q == PCLS_LOAD_WAIT) && ee_present_i && ee_valid_i;

	// EEPROM load sequencing after reset
	always_comb begin
		load_d = load_q;
		unique case (load_q)
			PCLS_LOAD_WAIT: begin
				if (!ee_present_i || ee_valid_i) begin
					load_d = PCLS_LOAD_DONE;
				end
			end
			PCLS_LOAD_DONE: begin
				load_d = PCLS_LOAD_DONE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			load_q <= PCLS_LOAD_WAIT;
		end else begin
			load_q <= load_d;
		end
	end

	assign ee_loaded_o = (load_q == PCLS_LOAD_DONE);

	// Latency hint: default, then EEPROM word; host never writes it
	// A late word after the load phase is ignored until the next reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lat_q <= `PCLS_LAT_RESET;
		end else if (ee_take) begin
			lat_q <= ee_data_i;
		end
	end

	// Hint fields as the host sees them
	assign max_latency = lat_q[`PCLS_LAT_MAXLAT_HI:`PCLS_LAT_MAXLAT_LO];
	assign min_grant   = lat_q[`PCLS_LAT_MINGNT_HI:`PCLS_LAT_MINGNT_LO];
	assign hint_word   = upper_half({max_latency, min_grant});

	// Endian control: only the swap bit is writable
	// A change applies to quadlets taken after the write edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			swap_q <= `PCLS_END_RESET;
		end else if (swap_wr) begin
			swap_q <= cfg_wdata_i[`PCLS_END_SWAP_BIT];
		end
	end

	// Swap state to the outside
	assign swap_en_o = swap_q;

	// Reserved control bits tie low
	assign endian_word = {`PCLS_END_RSVD_ZERO, swap_q};

	// Capability header: fixed kind code, end of the list
	assign cap_word = lower_half({`PCLS_CAP_NEXT_PTR, `PCLS_CAP_KIND_CODE});

	// Read multiplexer; unmapped dwords read zero
	// Upper half of the capability dword belongs to logic outside this slice
	always_comb begin
		rdata_d = `PCLS_ZERO32;
		unique case (dw_addr)
			`PCLS_DW_LATENCY: begin
				rdata_d = hint_word;
			end
			`PCLS_DW_ENDIAN: begin
				rdata_d = endian_word;
			end
			`PCLS_DW_CAPHDR: begin
				rdata_d = cap_word;
			end
			default: begin
				rdata_d = `PCLS_ZERO32;
			end
		endcase
	end

	// Answer every access one cycle later, writes included
	// Dropped writes are still answered so the host never stalls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ack_o <= 1'b0;
		end else begin
			cfg_ack_o <= cfg_req_i;
		end
	end

	// Read data holds until the next read
	// Writes leave it alone so the last read stays visible
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_rdata_o <= `PCLS_ZERO32;
		end else if (rd_req) begin
			cfg_rdata_o <= rdata_d;
		end
	end

	// Write direction swap, host towards core
	// Both directions share one swap bit, so the host sees one byte order
	pcls_quad_swap u_wr_swap (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.swap_i  (swap_q),
		.valid_i (wr_valid_i),
		.data_i  (wr_data_i),
		.valid_o (wr_valid_o),
		.data_o  (wr_data_o)
	);

	// Read direction swap
	pcls_quad_swap u_rd_swap (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.swap_i  (swap_q),
		.valid_i (rd_valid_i),
		.data_i  (rd_data_i),
		.valid_o (rd_valid_o),
		.data_o  (rd_data_o)
	);
endmodule

// ===== pcls_chk_assertions.sv
// Checker for the configuration slice, bound to its top ports.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module pcls_chk (
	input wire logic                  clk_i,        // Clock
	input wire logic                  rst_i,        // Reset
	input wire logic                  cfg_req_i,    // Request
	input wire logic                  cfg_we_i,     // Write
	input wire pcls_pkg::pcls_addr_t  cfg_addr_i,   // Address
	input wire logic                  cfg_ack_o,    // Ack
	input wire pcls_pkg::pcls_dword_t cfg_rdata_o,  // Read data
	input wire logic                  ee_present_i, // EEPROM fitted
	input wire logic                  ee_valid_i,   // EEPROM strobe
	input wire logic                  ee_loaded_o,  // Load done
	input wire logic                  swap_en_o,    // Swap bit
	input wire logic                  wr_valid_i,   // Quadlet in
	input wire pcls_pkg::pcls_dword_t wr_data_i,    // Quadlet data in
	input wire logic                  wr_valid_o,   // Quadlet out
	input wire pcls_pkg::pcls_dword_t wr_data_o     // Quadlet data out
);
	import pcls_pkg::*;
	logic rd_lat, rd_end, rd_cap;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Read decodes per dword
	assign rd_lat = cfg_req_i && !cfg_we_i && cfg_addr_i[7:2] == 6'h0f;
	assign rd_end = cfg_req_i && !cfg_we_i && cfg_addr_i[7:2] == 6'h10;
	assign rd_cap = cfg_req_i && !cfg_we_i && cfg_addr_i[7:2] == 6'h11;
	property p_ack; cfg_req_i |=> cfg_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ld; ee_valid_i && ee_present_i && !ee_loaded_o |=> ee_loaded_o; endproperty
	a_ld: assert property (p_ld) else $error("no load");
	property p_def; rd_lat && !ee_present_i && ee_loaded_o |=> cfg_rdata_o[31:16] == 16'h0402; endproperty
	a_def: assert property (p_def) else $error("bad default");
	property p_swp; wr_valid_i && swap_en_o |=> wr_valid_o
		&& wr_data_o == {$past(wr_data_i[7:0]), $past(wr_data_i[15:8]),
		$past(wr_data_i[23:16]), $past(wr_data_i[31:24])}; endproperty
	a_swp: assert property (p_swp) else $error("bad swap");
	property p_ctl; rd_end |=> cfg_rdata_o == {31'h0, swap_en_o}; endproperty
	a_ctl: assert property (p_ctl) else $error("bad control");
	property p_rst; $fell(rst_i) |-> !swap_en_o; endproperty
	a_rst: assert property (p_rst) else $error("swap after reset");
	property p_id; rd_cap |=> cfg_rdata_o[7:0] == 8'h01; endproperty
	a_id: assert property (p_id) else $error("bad kind code");
	property p_nxt; rd_cap |=> cfg_rdata_o[15:8] == 8'h00; endproperty
	a_nxt: assert property (p_nxt) else $error("bad next");
	// Main scenarios
	c_wr: cover property (cfg_req_i && cfg_we_i);
	c_sw: cover property (swap_en_o && wr_valid_i);
	c_ld: cover property ($rose(ee_loaded_o));
endmodule

// ===== pcls_ee_model.sv
// EEPROM side model: presence level and one hint word on request.
// Assumes the bench asks for the word after reset.
`timescale 1ns/1ps
module pcls_ee_model (
	input  wire logic                 clk_i,        // Clock
	input  wire logic                 fit_i,        // EEPROM fitted
	input  wire logic                 send_i,       // Send word now
	input  wire pcls_pkg::pcls_half_t word_i,       // Word to send
	output logic                      ee_present_o, // Presence
	output logic                      ee_valid_o,   // Word strobe
	output pcls_pkg::pcls_half_t      ee_data_o     // Word, inverted when idle
);
	import pcls_pkg::*;
	// Word source
	always_ff @(posedge clk_i) begin
		ee_present_o <= fit_i;
		ee_valid_o <= send_i & fit_i;
		ee_data_o <= send_i ? word_i : ~word_i;
	end
endmodule

// ===== pcls_cfg_slice_tb.sv
// Bench for the configuration slice with the EEPROM model.
// Assumes the one-cycle request and ack port of the slice.
`timescale 1ns/1ps
module pcls_cfg_slice_tb;
	import pcls_pkg::*;
	logic clk_i, rst_i, cfg_req_i, cfg_we_i, wr_valid_i, rd_valid_i, fit, send;
	logic ee_present_i, ee_valid_i, cfg_ack_o, ee_loaded_o, swap_en_o, wr_valid_o, rd_valid_o;
	pcls_addr_t cfg_addr_i;
	pcls_be_t cfg_be_i;
	pcls_half_t ee_data_i, word;
	pcls_dword_t cfg_wdata_i, cfg_rdata_o, wr_data_i, wr_data_o, rd_data_i, rd_data_o;
	int bad_count, total_checks, cyc;
	pcls_cfg_slice DUT (.clk_i, .rst_i, .cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_be_i,
		.cfg_wdata_i, .cfg_ack_o, .cfg_rdata_o, .ee_present_i, .ee_valid_i, .ee_data_i,
		.ee_loaded_o, .swap_en_o, .wr_valid_i, .wr_data_i, .wr_valid_o, .wr_data_o,
		.rd_valid_i, .rd_data_i, .rd_valid_o, .rd_data_o);
	pcls_ee_model u_ee (.clk_i, .fit_i(fit), .send_i(send), .word_i(word),
		.ee_present_o(ee_present_i), .ee_valid_o(ee_valid_i), .ee_data_o(ee_data_i));
	function automatic pcls_dword_t sw(input pcls_dword_t d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, s);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// One access; request held high for a following call
	task automatic cfg(input logic w, input pcls_addr_t a, input pcls_be_t b, input pcls_dword_t d, e);
		{cfg_req_i, cfg_we_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = {1'b1, w, a, b, d};
		@(posedge clk_i);
		#1;
		chk("ack", 1, cfg_ack_o);
		if (!w) chk("rdata", e, cfg_rdata_o);
	endtask
	task automatic xfer(input pcls_dword_t d, input logic s);
		{wr_valid_i, rd_valid_i, wr_data_i, rd_data_i} = {2'b11, d, ~d};
		@(posedge clk_i);
		#1;
		chk("wr", s ? sw(d) : d, wr_data_o);
		chk("rd", s ? sw(~d) : ~d, rd_data_o);
		chk("valids", 2'b11, {wr_valid_o, rd_valid_o});
	endtask
	task automatic idle;
		{cfg_req_i, wr_valid_i, rd_valid_i, send} = '0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic rst(input logic f);
		{rst_i, fit} = {1'b1, f};
		repeat (2) @(posedge clk_i);
		#1;
		rst_i = 0;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		clk_i = 0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			complete_run;
		end
	end
	initial begin
		{cfg_req_i, cfg_we_i, cfg_addr_i, cfg_be_i, cfg_wdata_i, send} = '0;
		{wr_valid_i, rd_valid_i, wr_data_i, rd_data_i, word} = {66'h0, 16'h5a3c};
		rst(1);
		send = 1;
		@(posedge clk_i);
		#1;
		idle;
		idle;
		chk("loaded", 1, ee_loaded_o);
		cfg(0, 8'h3c, 4'hf, 0, 32'h5a3c0000);
		cfg(1, 8'h3c, 4'hf, '1, 0);
		cfg(1, 8'h3e, 4'hf, 0, 0);
		word = 16'h0077;
		send = 1;
		cfg(0, 8'h3c, 4'hf, 0, 32'h5a3c0000);
		idle;
		cfg(0, 8'h3c, 4'hf, 0, 32'h5a3c0000);
		cfg(0, 8'h40, 4'hf, 0, 0);
		cfg(1, 8'h40, 4'he, '1, 0);
		cfg(0, 8'h40, 4'hf, 0, 0);
		cfg(1, 8'h40, 4'h1, '1, 0);
		cfg(0, 8'h40, 4'hf, 0, 1);
		cfg(1, 8'h44, 4'hf, '1, 0);
		cfg(0, 8'h44, 4'hf, 0, 1);
		cfg(1, 8'h80, 4'hf, '1, 0);
		cfg(0, 8'h80, 4'hf, 0, 0);
		xfer(32'h11223344, 1);
		xfer(32'ha1b2c3d4, 1);
		idle;
		cfg(1, 8'h40, 4'h1, 0, 0);
		xfer(32'h11223344, 0);
		idle;
		rst(0);
		idle;
		chk("loaded", 1, ee_loaded_o);
		cfg(0, 8'h3c, 4'hf, 0, 32'h04020000);
		cfg(0, 8'h40, 4'hf, 0, 0);
		idle;
		complete_run;
	end
endmodule
bind pcls_cfg_slice pcls_chk u_chk (.clk_i, .rst_i, .cfg_req_i, .cfg_we_i, .cfg_addr_i,
	.cfg_ack_o, .cfg_rdata_o, .ee_present_i, .ee_valid_i, .ee_loaded_o, .swap_en_o,
	.wr_valid_i, .wr_data_i, .wr_valid_o, .wr_data_o);
